// ### core/nvw_regs.svh
// Register offsets, fields, unlock keys and timing counts of the EEPROM control
// Operation
// - Core loads address and data before writing
// - Write needs 55h, AAh, then start bit
// - Software masks interrupts during unlock sequence
// - Start bit ignored while write-allow clear
// - Write-allow changed only by software, power-up; code also clears it on an external reset request
// - Clearing write-allow never stops ongoing write
// - Completion clears start bit, sets done flag
// - Done flag cleared only by software; code also clears it on an external reset request
// - Power-up clears write-allow, blocks writes 72ms
// - Code protection never scrambles data access
// - Software may verify writes by reading back
// - Software keeps write-allow clear when idle
// - Read loads data register next cycle, self-clears; code ignores the read bit while a write is busy
// - Start bits set-only, clear on completion
// - External or watchdog reset mid-write flags abort
// - Unlock port stores nothing, reads zero
`ifndef NVW_REGS_SVH
`define NVW_REGS_SVH
`define NVW_OFS_DATA      8'h08
`define NVW_OFS_ADDR      8'h09
`define NVW_OFS_CTRL      8'h88
`define NVW_OFS_UNLOCK    8'h89
`define NVW_BIT_RD        0
`define NVW_BIT_WR        1
`define NVW_BIT_ALLOW     2
`define NVW_BIT_ABORT     3
`define NVW_BIT_DONE      4
`define NVW_KEY_FIRST     8'h55
`define NVW_KEY_SECOND    8'hAA
`define NVW_ZERO_BYTE     8'h00
`define NVW_POWERUP_MS     72
`define NVW_CLK_KHZ        25000
`define NVW_POWERUP_CYCLES (`NVW_POWERUP_MS * `NVW_CLK_KHZ)
`define NVW_WRITE_CYCLES  1000
`endif

// ### core/nvw_pkg.sv
// Types used by the device end of the EEPROM control link
package nvw_pkg;
    typedef enum logic [1:0] {
        NVW_LK_IDLE  = 2'b00,
        NVW_LK_GOT55 = 2'b01,
        NVW_LK_ARMED = 2'b10
    } nvw_lock_e;
    typedef enum logic [1:0] {
        NVW_CMD_NONE  = 2'b00,
        NVW_CMD_WRITE = 2'b01,
        NVW_CMD_READ  = 2'b10
    } nvw_cmd_e;
endpackage : nvw_pkg

// ### core/nvw_link_if.sv
// Register access link between processor core and EEPROM control
`timescale 1ns/1ps
`default_nettype none
interface nvw_link_if;
    logic       regWrite;
    logic       regRead;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic       extReset;
    modport device (
        input  regWrite,
        input  regRead,
        input  regAddr,
        input  regWdata,
        input  extReset,
        output regRdata
    );
    modport core (
        output regWrite,
        output regRead,
        output regAddr,
        output regWdata,
        output extReset,
        input  regRdata
    );
endinterface : nvw_link_if
`default_nettype wire

// ### core/nvw_core_port.sv
// Processor-side end: runs register reads and writes issued by its user
`timescale 1ns/1ps
`default_nettype none
`include "nvw_regs.svh"
module nvw_core_port (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    nvw_link_if.core         link,
    input  wire logic        reqValid,
    input  wire logic        reqWrite,
    input  wire logic [7:0]  reqAddr,
    input  wire logic [7:0]  reqData,
    input  wire logic        resetReq,
    output logic             rspValid,
    output logic [7:0]       rspData
);
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       xrst;
        logic       pend;
        logic       pend2;
        logic       rspV;
        logic [7:0] rspD;
    } nvw_cp_s;
    nvw_cp_s st;
    nvw_cp_s next_st;

    // One access per instruction slot; user sequences
    always_comb begin
        next_st      = st;
        next_st.wr   = reqValid && reqWrite;
        next_st.rd   = reqValid && !reqWrite;
        next_st.xrst = resetReq;
        next_st.rspV = 1'b0;
        next_st.pend = next_st.rd;
        // Device answers one cycle after it sees the new address
        next_st.pend2 = st.pend;
        if (reqValid) begin
            next_st.addr  = reqAddr;
            next_st.wdata = reqData;
        end
        if (st.pend2) begin
            next_st.rspV = 1'b1;
            next_st.rspD = link.regRdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.regWrite = st.wr;
    assign link.regRead  = st.rd;
    assign link.regAddr  = st.addr;
    assign link.regWdata = st.wdata;
    assign link.extReset = st.xrst;
    assign rspValid      = st.rspV;
    assign rspData       = st.rspD;
endmodule : nvw_core_port
`default_nettype wire

// ### core/nvw_eeprom_ctrl.sv
// Device end: data EEPROM registers, unlock tracker and write timing
`timescale 1ns/1ps
`default_nettype none
`include "nvw_regs.svh"
module nvw_eeprom_ctrl #(
    parameter int DEPTH        = 64,
    parameter int WRITE_CYCLES = `NVW_WRITE_CYCLES,
    parameter int POWERUP_CYCLES = `NVW_POWERUP_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    nvw_link_if.device       link,
    output logic             writeBusy,
    output logic             writeDone
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [7:0]            data;
        logic [7:0]            addr;
        logic                  rd;
        logic                  wr;
        logic                  wrAllow;
        logic                  wrAbort;
        logic                  doneFlag;
        nvw_pkg::nvw_lock_e    lock;
        logic [31:0]           wcnt;
        logic [31:0]           pcnt;
        logic                  pwrOk;
        logic [7:0]            rdata;
        logic                  xrstQ;
    } nvw_dev_s;
    nvw_dev_s st;
    nvw_dev_s next_st;
    logic [7:0] mem [DEPTH];
    logic       memWe;
    logic       hit;

    function automatic logic isAt(input logic [7:0] ofs);
        isAt = link.regAddr == ofs;
    endfunction : isAt

    always_comb begin
        next_st = st;
        memWe   = 1'b0;
        hit     = link.regWrite && isAt(`NVW_OFS_CTRL);
        if (st.pcnt != 32'(POWERUP_CYCLES)) begin
            next_st.pcnt = st.pcnt + 32'd1;
        end else begin
            next_st.pwrOk = 1'b1;
        end
        if (st.rd) begin
            next_st.data = mem[st.addr[AW-1:0]];
            next_st.rd   = 1'b0;
        end
        if (st.wr) begin
            if (st.wcnt == 32'(WRITE_CYCLES - 1)) begin
                memWe            = 1'b1;
                next_st.wr       = 1'b0;
                next_st.doneFlag = 1'b1;
                next_st.wcnt = '0;
            end else begin
                next_st.wcnt = st.wcnt + 32'd1;
            end
        end
        // Any access other than the expected next step drops the tracker
        if (link.regWrite || link.regRead) begin
            next_st.lock = nvw_pkg::NVW_LK_IDLE;
        end
        if (link.regWrite) begin
            unique case (link.regAddr)
                `NVW_OFS_DATA: next_st.data = link.regWdata;
                `NVW_OFS_ADDR: next_st.addr = link.regWdata;
                `NVW_OFS_UNLOCK: begin
                    if (link.regWdata == `NVW_KEY_FIRST) begin
                        next_st.lock = nvw_pkg::NVW_LK_GOT55;
                    end else if (link.regWdata == `NVW_KEY_SECOND
                                 && st.lock == nvw_pkg::NVW_LK_GOT55) begin
                        next_st.lock = nvw_pkg::NVW_LK_ARMED;
                    end
                end
                default: ;
            endcase
        end
        if (hit) begin
            next_st.wrAllow = link.regWdata[`NVW_BIT_ALLOW];
            next_st.wrAbort = link.regWdata[`NVW_BIT_ABORT];
            // Hardware set beats software clear of the done flag
            if (!(st.wr && memWe)) begin
                next_st.doneFlag = link.regWdata[`NVW_BIT_DONE];
            end
            if (link.regWdata[`NVW_BIT_RD] && !st.wr) begin
                next_st.rd = 1'b1;
            end
            if (link.regWdata[`NVW_BIT_WR] && st.wrAllow && st.pwrOk
                && st.lock == nvw_pkg::NVW_LK_ARMED && !st.wr) begin
                next_st.wr = 1'b1;
            end
        end
        // Reset request mid-write aborts; address and data are kept
        if (link.extReset) begin
            next_st.wrAbort  = st.wrAbort | st.wr;
            next_st.wr       = 1'b0;
            next_st.rd       = 1'b0;
            next_st.wrAllow  = 1'b0;
            next_st.doneFlag = 1'b0;
            next_st.wcnt  = '0;
            next_st.lock  = nvw_pkg::NVW_LK_IDLE;
            memWe         = 1'b0;
        end
        unique case (link.regAddr)
            `NVW_OFS_DATA: next_st.rdata = st.data;
            `NVW_OFS_ADDR: next_st.rdata = st.addr;
            `NVW_OFS_CTRL: next_st.rdata = {3'b000, st.doneFlag, st.wrAbort,
                                            st.wrAllow, st.wr, st.rd};
            default:       next_st.rdata = `NVW_ZERO_BYTE;
        endcase
    end

    // Contents stored plain regardless of protection
    always_ff @(posedge ref_clk) begin
        if (memWe) begin
            mem[st.addr[AW-1:0]] <= st.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.regRdata = st.rdata;
    assign writeBusy     = st.wr;
    assign writeDone     = st.doneFlag;
endmodule : nvw_eeprom_ctrl
`default_nettype wire

// ### tb/nvw_link_assertions.sv
// Assertions on the EEPROM control link
`timescale 1ns/1ps
`default_nettype none
module nvw_link_assertions #(
    parameter int POWERUP_CYCLES = 20
) (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic       extReset,
    input wire logic       writeBusy,
    input wire logic       writeDone
);
    logic [7:0] upCnt;
    logic       ctlWr;
    assign ctlWr = regWrite && regAddr == 8'h88;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            upCnt <= 8'h00;
        end else if (upCnt != 8'hFF) begin
            upCnt <= upCnt + 8'h01;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    unlock_zero_a: assert property (
        regAddr == 8'h89 |=> regRdata == 8'h00) else $error("unlock read");
    start_cmd_a: assert property (
        $rose(writeBusy) |-> $past(ctlWr && regWdata[1])) else $error("start");
    start_keys_a: assert property (
        $rose(writeBusy) |-> $past(regWdata, 2) == 8'hAA
        && $past(regWdata, 3) == 8'h55) else $error("keys");
    powerup_block_a: assert property (
        $rose(writeBusy) |-> upCnt >= POWERUP_CYCLES) else $error("powerup");
    // Repetition count cannot be a parameter, so the bench fixes it at 8
    busy_len_a: assert property (disable iff (rst || extReset)
        $rose(writeBusy) |-> writeBusy[*8] ##1 !writeBusy) else $error("len");
    done_set_a: assert property (
        $fell(writeBusy) && !$past(extReset) |-> writeDone) else $error("done");
    done_hold_a: assert property (
        $fell(writeDone) |-> $past(ctlWr && !regWdata[4]) || $past(extReset))
        else $error("done cleared");
    abort_stop_a: assert property (
        extReset && writeBusy |=> !writeBusy) else $error("abort");
    cover property ($rose(writeBusy));
    cover property ($rose(writeDone));
    cover property (extReset && writeBusy);
endmodule : nvw_link_assertions
`default_nettype wire

// ### tb/test_data_eeprom_write_control.sv
// Bench joining core port and EEPROM control back to back
`timescale 1ns/1ps
`default_nettype none
module test_data_eeprom_write_control;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       reqValid = 1'b0;
    logic       reqWrite = 1'b0;
    logic [7:0] reqAddr = 8'h00;
    logic [7:0] reqData = 8'h00;
    logic       resetReq = 1'b0;
    logic       rspValid;
    logic [7:0] rspData;
    logic       writeBusy;
    logic       writeDone;
    int         err_total = 0;
    int         total_checks = 0;
    nvw_link_if link ();
    nvw_core_port nvw_core_port_i (.ref_clk(ref_clk), .rst(rst), .link(link),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqData(reqData), .resetReq(resetReq), .rspValid(rspValid),
        .rspData(rspData));
    // Short counts keep the run brief; the checker assumes them
    nvw_eeprom_ctrl #(.WRITE_CYCLES(8), .POWERUP_CYCLES(20)) nvw_eeprom_ctrl_i (
        .ref_clk(ref_clk), .rst(rst), .link(link), .writeBusy(writeBusy),
        .writeDone(writeDone));
    nvw_link_assertions #(.POWERUP_CYCLES(20)) nvw_link_assertions_i (
        .ref_clk(ref_clk), .rst(rst), .regWrite(link.regWrite),
        .regAddr(link.regAddr), .regWdata(link.regWdata),
        .regRdata(link.regRdata), .extReset(link.extReset),
        .writeBusy(writeBusy), .writeDone(writeDone));
    always #20 ref_clk = ~ref_clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            reqValid = 1'b0;
            resetReq = 1'b0;
        end
    endtask : idle
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge ref_clk);
        #1;
        reqValid = 1'b1;
        reqWrite = w;
        reqAddr = a;
        reqData = d;
    endtask : acc
    task automatic rd(input logic [7:0] a, exp);
        acc(1'b0, a, 8'h00);
        idle(1);
        for (int i = 0; i < 6 && rspValid !== 1'b1; i++) idle(1);
        if (rspValid !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
        chk(rspData, exp);
    endtask : rd
    // Unlock steps go out on consecutive cycles; the tracker only forbids other accesses between them
    task automatic seq(input logic [7:0] a, d, en);
        acc(1'b1, 8'h09, a);
        acc(1'b1, 8'h08, d);
        acc(1'b1, 8'h88, en);
        acc(1'b1, 8'h89, 8'h55);
        acc(1'b1, 8'h89, 8'hAA);
        acc(1'b1, 8'h88, en | 8'h02);
        idle(3);
    endtask : seq
    task automatic wait_done();
        for (int i = 0; i < 20 && writeDone !== 1'b1; i++) idle(1);
        if (writeDone !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
    endtask : wait_done
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        seq(8'h05, 8'h3C, 8'h04);
        chk(8'(writeBusy), 8'h00);
        idle(20);
        seq(8'h05, 8'h3C, 8'h04);
        chk(8'(writeBusy), 8'h01);
        wait_done();
        rd(8'h88, 8'h14);
        acc(1'b1, 8'h08, 8'h00);
        acc(1'b1, 8'h88, 8'h05);
        idle(2);
        rd(8'h08, 8'h3C);
        rd(8'h88, 8'h04);
        acc(1'b1, 8'h89, 8'h55);
        acc(1'b0, 8'h08, 8'h00);
        acc(1'b1, 8'h89, 8'hAA);
        acc(1'b1, 8'h88, 8'h06);
        idle(3);
        chk(8'(writeBusy), 8'h00);
        seq(8'h05, 8'h3C, 8'h00);
        chk(8'(writeBusy), 8'h00);
        seq(8'h06, 8'h81, 8'h04);
        acc(1'b1, 8'h88, 8'h00);
        idle(1);
        chk(8'(writeBusy), 8'h01);
        wait_done();
        rd(8'h88, 8'h10);
        acc(1'b1, 8'h08, 8'h00);
        acc(1'b1, 8'h88, 8'h01);
        idle(2);
        rd(8'h08, 8'h81);
        seq(8'h07, 8'h5A, 8'h04);
        resetReq = 1'b1;
        idle(3);
        chk(8'(writeBusy), 8'h00);
        rd(8'h88, 8'h08);
        rd(8'h09, 8'h07);
        rd(8'h08, 8'h5A);
        rd(8'h89, 8'h00);
        report_and_stop();
    end
endmodule : test_data_eeprom_write_control
`default_nettype wire
